/* pso_bit_buffer.sv */
// two-entry buffer holding bits shifted out of the last stage
`timescale 1ns/100ps
module pso_bit_buffer #(
  parameter int WIDTH = pso_pkg::BUF_WIDTH,
  parameter int DEPTH = pso_pkg::BUF_DEPTH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // entry 0 is the head, so the head word and valid come straight from flops
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] used;
  logic [DEPTH-1:0] next_used;
  logic pop;
  logic push;
  // occupancy once a pop has moved entries down, and the slots whose lower neighbour is taken
  logic [DEPTH-1:0] kept;
  logic [DEPTH-1:0] below;

  assign pop = used[0] & outReady;
  assign push = inValid & inReady;
  assign outValid = used[0];
  assign outData = mem[0];

  // occupancy after a pop shifts entries down, then a push fills the first free slot;
  // a slot can take the push only when every slot beneath it is still occupied
  assign kept = pop ? (used >> 1) : used;
  assign below = {kept[DEPTH-2:0], 1'b1};
  assign next_used = push ? below : kept;

  // occupancy flags; ready is registered from next_used, so it sees the drain side's pop only one cycle later
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      used <= '0;
      inReady <= 1'b1;
    end else begin
      used <= next_used;
      inReady <= ~next_used[DEPTH-1];
    end
  end

  // data moves down on a pop; the pushed word lands in the slot just freed or first empty
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          mem[i] <= '0;
        end else begin
          if (push && !kept[i] && below[i]) begin
            mem[i] <= inData;
          end else if (pop) begin
            mem[i] <= (i == DEPTH - 1) ? mem[i] : mem[(i + 1) % DEPTH];
          end
        end
      end
    end
  endgenerate

  // a full buffer never claims ready
  full_ready_a: assert property (@(posedge clock) disable iff (sys_rst)
    used[DEPTH-1] |-> !inReady)
    else $error("buffer full but ready high");

endmodule

/* pso_host_model.sv */
// host model: drives the register's pins and drains the shifted-out bit stream
`timescale 1ns/100ps
module pso_host_model (
  input wire logic clock,
  output logic [pso_pkg::STAGES-1:0] parallelIn,
  output logic serial_data_in,
  output logic loadSelect,
  output logic clockA,
  output logic clockB,
  input wire logic shiftedValid,
  output logic shiftedReady,
  input wire logic shiftedBit
);
  logic got[$];

  // quiet pins at time zero: load mode, both clocks low, receiver ready
  initial begin
    parallelIn = 8'h00;
    serial_data_in = 1'b0;
    loadSelect = 1'b0;
    clockA = 1'b0;
    clockB = 1'b0;
    shiftedReady = 1'b1;
  end

  // one pin phase; held 8 clocks since shorter levels may never pass the synchronisers
  task automatic drive(input logic l, input logic [pso_pkg::STAGES-1:0] p, input logic s,
                       input logic a, input logic b);
    @(posedge clock);
    loadSelect <= l;
    parallelIn <= p;
    serial_data_in <= s;
    clockA <= a;
    clockB <= b;
    repeat (8) @(posedge clock);
  endtask

  // receiver side may stall to fill the buffer
  task automatic setReady(input logic r);
    @(posedge clock);
    shiftedReady <= r;
  endtask

  // collect every bit taken from the buffer head
  always @(posedge clock) begin
    if (shiftedValid === 1'b1 && shiftedReady === 1'b1) begin
      got.push_back(shiftedBit);
    end
  end
endmodule

/* pso_pkg.sv */
// shared constants for the parallel/serial-in, serial-out shift register
package pso_pkg;

  // number of cascaded storage stages
  localparam int STAGES = 8;

  // pins that pass the input synchroniser: 8 parallel, serial, load select, two clocks
  localparam int PIN_COUNT = 12;

  // positions of the single-bit pins inside the synchronised pin vector
  localparam int PIN_SERIAL = 8;
  localparam int PIN_LOAD = 9;
  localparam int PIN_CLK_A = 10;
  localparam int PIN_CLK_B = 11;

  // flip-flops in each pin synchroniser
  localparam int SYNC_FLOPS = 3;

  // shifted-out bit buffer shape
  localparam int BUF_WIDTH = 1;
  localparam int BUF_DEPTH = 2;

  // values after reset
  localparam logic [STAGES-1:0] STAGES_RST = 8'h00;
  localparam logic [PIN_COUNT-1:0] PINS_RST = 12'h000;
  localparam logic [SYNC_FLOPS-1:0] SYNC_RST = 3'h0;

  // operating mode of the register, from the load select level
  typedef enum logic [0:0] {
    PSO_LOAD = 1'b0,
    PSO_SHIFT = 1'b1
  } pso_mode_e;

endpackage

/* pso_shift_register.sv */
// eight-stage parallel or serial load, serial out shift register with NOR clock pair
`timescale 1ns/100ps
// Function
// - eight cascaded stages; eighth stage drives true and inverted outputs.
// - load select low copies parallel inputs into stages, ignoring clocks and serial.
// - load select high shifts only on a rising edge of either clock.
// - internal shift clock is the NOR of the two clock inputs.
// - either clock held high blocks the other; stages stay unchanged.
// - second clock low, first clock rising gives exactly one shift.
// - first clock low, second clock rising gives exactly one identical shift.
// - a shift loads serial data into stage one and moves every stage up.
// - fully static; any clock rate down to zero works.
module pso_shift_register (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [pso_pkg::STAGES-1:0] parallelIn,
  input wire logic serial_data_in,
  input wire logic loadSelect,
  input wire logic clockA,
  input wire logic clockB,
  output logic last_stage_out,
  output logic last_stage_out_n,
  output logic shiftedValid,
  input wire logic shiftedReady,
  output logic shiftedBit
);

  // raw pin vector in synchroniser order
  logic [pso_pkg::PIN_COUNT-1:0] pinRaw;
  // agreed pin levels after the three-flop synchronisers
  logic [pso_pkg::PIN_COUNT-1:0] pinSync;
  // storage stages, bit 0 is first_stage
  logic [pso_pkg::STAGES-1:0] stages;
  logic [pso_pkg::STAGES-1:0] next_stages;
  logic first_stage;
  // previous NOR level, for edge detection
  logic norPrev;
  logic norNow;
  logic norFall;
  // a detected shift waiting for room in the buffer, and the serial bit it captured
  logic pending;
  logic next_pending;
  logic pendBit;
  logic shiftDo;
  logic bufReady;
  pso_pkg::pso_mode_e mode;

  assign pinRaw = {clockB, clockA, loadSelect, serial_data_in, parallelIn};

  // three flops per pin; the first is only ever read by the second
  genvar p;
  generate
    for (p = 0; p < pso_pkg::PIN_COUNT; p++) begin : g_sync
      logic [pso_pkg::SYNC_FLOPS-1:0] chain;
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          chain <= pso_pkg::SYNC_RST;
        end else begin
          chain <= {chain[pso_pkg::SYNC_FLOPS-2:0], pinRaw[p]};
        end
      end
      // a change counts only once the second and third flops agree
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          pinSync[p] <= pso_pkg::PINS_RST[p];
        end else if (chain[1] == chain[2]) begin
          pinSync[p] <= chain[2];
        end
      end
    end
  endgenerate

  // mode follows the load select level
  assign mode = pinSync[pso_pkg::PIN_LOAD] ? pso_pkg::PSO_SHIFT : pso_pkg::PSO_LOAD;

  // internal shift clock is a NOR of the pair; a rise on either input while the other is low is a NOR fall
  assign norNow = ~(pinSync[pso_pkg::PIN_CLK_A] | pinSync[pso_pkg::PIN_CLK_B]);
  // an input held high pins the NOR low, so the other input cannot make an edge
  assign norFall = norPrev & ~norNow;

  // remember the NOR level; the reset value is high so a clock already high at
  // release shows as one edge, matching a part that powers up with clocks low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      norPrev <= 1'b1;
    end else begin
      norPrev <= norNow;
    end
  end

  // a shift is performed only when the buffer can take the bit pushed out
  assign shiftDo = pending & bufReady & (mode == pso_pkg::PSO_SHIFT);

  // pending shift: a new edge wins over the clear of the one being served
  always_comb begin
    next_pending = pending;
    case (mode)
      pso_pkg::PSO_LOAD: begin
        next_pending = 1'b0;
      end
      pso_pkg::PSO_SHIFT: begin
        if (norFall) begin
          next_pending = 1'b1;
        end else if (shiftDo) begin
          next_pending = 1'b0;
        end
      end
      default: begin
        next_pending = 1'b0;
      end
    endcase
  end

  // pending flag and the serial level sampled at the clock edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= 1'b0;
      pendBit <= 1'b0;
    end else begin
      pending <= next_pending;
      if (norFall) begin
        pendBit <= pinSync[pso_pkg::PIN_SERIAL];
      end
    end
  end

  // stage update: parallel copy, one-bit shift, or hold
  always_comb begin
    next_stages = stages;
    case (mode)
      pso_pkg::PSO_LOAD: begin
        next_stages = pinSync[pso_pkg::STAGES-1:0];
      end
      pso_pkg::PSO_SHIFT: begin
        // both clock inputs produce the same single shift
        if (shiftDo) begin
          next_stages = {stages[pso_pkg::STAGES-2:0], pendBit};
        end
      end
      default: begin
        next_stages = stages;
      end
    endcase
  end

  // stages hold without any edge, so a stopped clock pair loses nothing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stages <= pso_pkg::STAGES_RST;
    end else begin
      stages <= next_stages;
    end
  end

  // true and inverted last-stage outputs, each its own flop
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      last_stage_out <= pso_pkg::STAGES_RST[pso_pkg::STAGES-1];
      last_stage_out_n <= ~pso_pkg::STAGES_RST[pso_pkg::STAGES-1];
    end else begin
      last_stage_out <= next_stages[pso_pkg::STAGES-1];
      last_stage_out_n <= ~next_stages[pso_pkg::STAGES-1];
    end
  end

  assign first_stage = stages[0];

  // bits discarded from the eighth stage are offered to the receiver; a stall
  // holds the next shift back rather than dropping a bit
  pso_bit_buffer #(
    .WIDTH(pso_pkg::BUF_WIDTH),
    .DEPTH(pso_pkg::BUF_DEPTH)
  ) pso_bit_buffer_inst (
    .clock(clock),
    .sys_rst(sys_rst),
    .inValid(shiftDo),
    .inReady(bufReady),
    .inData(stages[pso_pkg::STAGES-1]),
    .outValid(shiftedValid),
    .outReady(shiftedReady),
    .outData(shiftedBit)
  );

  // complementary outputs always disagree
  out_complement_a: assert property (@(posedge clock) disable iff (sys_rst)
    last_stage_out_n == ~last_stage_out)
    else $error("last stage outputs not complementary");

  // parallel mode copies the agreed parallel pins one cycle later
  par_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_LOAD) |=> (stages == $past(pinSync[pso_pkg::STAGES-1:0])))
    else $error("parallel load did not copy inputs");

  // last-stage output follows the eighth parallel input in load mode
  par_last_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_LOAD) |=> (last_stage_out == $past(pinSync[pso_pkg::STAGES-1])))
    else $error("last stage does not follow eighth input");

  // shift mode with no shift leaves the stages alone
  shift_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_SHIFT) && !shiftDo |=> $stable(stages))
    else $error("stages changed without a shift");

  // a shift moves each stage up and puts the captured serial bit first
  shift_move_a: assert property (@(posedge clock) disable iff (sys_rst)
    shiftDo |=> (stages == {$past(stages[pso_pkg::STAGES-2:0]), $past(pendBit)}))
    else $error("shift did not move stages correctly");

  // a clock input held high for two samples blocks any edge from the other
  inhibit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (pinSync[pso_pkg::PIN_CLK_A] && $past(pinSync[pso_pkg::PIN_CLK_A])) ||
    (pinSync[pso_pkg::PIN_CLK_B] && $past(pinSync[pso_pkg::PIN_CLK_B])) |-> !norFall)
    else $error("edge seen while a clock input is held high");

  // a rising clock with the other low is recorded for one shift
  edge_record_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_SHIFT) && $rose(pinSync[pso_pkg::PIN_CLK_A] | pinSync[pso_pkg::PIN_CLK_B])
    && $past(norNow) |=> pending)
    else $error("clock edge not recorded");

  // a recorded shift with room in the buffer lands in it at the next edge
  serve_shift_a: assert property (@(posedge clock) disable iff (sys_rst)
    pending && bufReady && (mode == pso_pkg::PSO_SHIFT) |=> shiftedValid)
    else $error("ready buffer but shift not taken");

  // both clocks steady low in shift mode, with no shift pending, keep the outputs still
  idle_still_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_SHIFT) && !pending && norNow && norPrev |=> $stable(last_stage_out))
    else $error("output moved with clocks idle");

  // a stalled buffer keeps the pending shift alive
  stall_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    pending && !bufReady && (mode == pso_pkg::PSO_SHIFT) |=> pending && $stable(stages))
    else $error("pending shift lost under back-pressure");

  // the captured serial bit becomes the first stage
  first_in_a: assert property (@(posedge clock) disable iff (sys_rst)
    shiftDo |=> (first_stage == $past(pendBit)))
    else $error("first stage did not take serial bit");

  // parallel mode drops any recorded shift
  load_no_pend_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_LOAD) |=> !pending)
    else $error("shift kept pending in load mode");

  // the true output flop always mirrors the eighth stage
  out_eighth_a: assert property (@(posedge clock) disable iff (sys_rst)
    last_stage_out == stages[pso_pkg::STAGES-1])
    else $error("output differs from eighth stage");

  // the serial level is taken at the edge itself, not at the later shift
  serial_grab_a: assert property (@(posedge clock) disable iff (sys_rst)
    norFall |=> (pendBit == $past(pinSync[pso_pkg::PIN_SERIAL])))
    else $error("serial bit not captured at edge");

  // one edge yields one shift; pending survives only if a new edge arrived
  one_shift_a: assert property (@(posedge clock) disable iff (sys_rst)
    shiftDo |=> (pending == $past(norFall)))
    else $error("edge served more than once");

  // nothing but a clock edge creates a pending shift
  pend_from_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(pending) |-> $past(norFall))
    else $error("shift pending without an edge");

  // the OR of the two clock inputs falling lifts the NOR and must never count as an edge
  fall_no_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(pinSync[pso_pkg::PIN_CLK_A] | pinSync[pso_pkg::PIN_CLK_B]) |-> !norFall)
    else $error("falling clock seen as an edge");

  // with room at the head, the pushed bit is the old eighth stage
  out_bit_a: assert property (@(posedge clock) disable iff (sys_rst)
    shiftDo && (!shiftedValid || shiftedReady) |=> (shiftedBit == $past(stages[pso_pkg::STAGES-1])))
    else $error("discarded bit not offered");

  // stages move only through a parallel copy or a served shift
  stage_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
    !$stable(stages) |-> ($past(mode) == pso_pkg::PSO_LOAD) || $past(shiftDo))
    else $error("stages changed without cause");

  // a stalled receiver sees the same head bit until it takes it
  valid_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    shiftedValid && !shiftedReady |=> shiftedValid && $stable(shiftedBit))
    else $error("head bit lost while stalled");

  // the captured bit is not disturbed while a shift waits
  pend_bit_keep_a: assert property (@(posedge clock) disable iff (sys_rst)
    !norFall |=> $stable(pendBit))
    else $error("pending serial bit changed");

  // inverted output follows the eighth parallel input in load mode
  load_inv_out_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_LOAD) |=> (last_stage_out_n == !$past(pinSync[pso_pkg::STAGES-1])))
    else $error("inverted output does not follow input");

  // first clock rising with the second low records a shift
  rise_a_record_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_SHIFT) && $rose(pinSync[pso_pkg::PIN_CLK_A]) && !pinSync[pso_pkg::PIN_CLK_B]
    && !$past(pinSync[pso_pkg::PIN_CLK_B]) |=> pending)
    else $error("first clock edge not recorded");

  // second clock rising with the first low records a shift
  rise_b_record_a: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == pso_pkg::PSO_SHIFT) && $rose(pinSync[pso_pkg::PIN_CLK_B]) && !pinSync[pso_pkg::PIN_CLK_A]
    && !$past(pinSync[pso_pkg::PIN_CLK_A]) |=> pending)
    else $error("second clock edge not recorded");

endmodule

/* pso_shift_register_tb_top.sv */
// self-checking bench for the parallel/serial-in, serial-out shift register
`timescale 1ns/100ps
module pso_shift_register_tb_top;
  logic clock;
  logic sys_rst;
  logic [pso_pkg::STAGES-1:0] parallelIn;
  logic serial_data_in;
  logic loadSelect;
  logic clockA;
  logic clockB;
  logic last_stage_out;
  logic last_stage_out_n;
  logic shiftedValid;
  logic shiftedReady;
  logic shiftedBit;
  logic [pso_pkg::STAGES-1:0] expReg;
  logic expQ[$];
  int fails;
  int nCompared;

  pso_shift_register pso_shift_register_inst (.clock(clock), .sys_rst(sys_rst), .parallelIn(parallelIn),
    .serial_data_in(serial_data_in), .loadSelect(loadSelect), .clockA(clockA), .clockB(clockB),
    .last_stage_out(last_stage_out), .last_stage_out_n(last_stage_out_n), .shiftedValid(shiftedValid),
    .shiftedReady(shiftedReady), .shiftedBit(shiftedBit));

  pso_host_model pso_host_model_inst (.clock(clock), .parallelIn(parallelIn), .serial_data_in(serial_data_in),
    .loadSelect(loadSelect), .clockA(clockA), .clockB(clockB), .shiftedValid(shiftedValid),
    .shiftedReady(shiftedReady), .shiftedBit(shiftedBit));

  // 20 MHz system clock
  initial clock = 1'b0;
  always #25 clock = ~clock;

  task automatic check(input logic seen, input logic exp, input string what);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t %s: saw %b expected %b", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (fails == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic checkOut(input string what);
    check(last_stage_out, expReg[7], what);
    check(last_stage_out_n, ~expReg[7], what);
  endtask

  // one full clock pulse; the model records the bit that falls off the end
  task automatic shiftOnce(input logic useB, input logic sin);
    pso_host_model_inst.drive(1'b1, 8'hFF, sin, ~useB, useB);
    pso_host_model_inst.drive(1'b1, 8'hFF, sin, 1'b0, 1'b0);
    expQ.push_back(expReg[7]);
    expReg = {expReg[6:0], sin};
  endtask

  // bounded wait for the stream, then bit-by-bit comparison
  task automatic drainCheck(input string what);
    int i;
    for (i = 0; i < 400 && pso_host_model_inst.got.size() < expQ.size(); i++) begin
      @(posedge clock);
    end
    if (pso_host_model_inst.got.size() != expQ.size()) begin
      fails++;
      $display("BAD %0t %s: bit stream count wrong", $time, what);
      complete_run();
    end else begin
      while (expQ.size() > 0) begin
        check(pso_host_model_inst.got.pop_front(), expQ.pop_front(), what);
      end
    end
  endtask

  task automatic testLoad;
    logic [7:0] pats[3] = '{8'hA5, 8'h5A, 8'h3C};
    foreach (pats[i]) begin
      pso_host_model_inst.drive(1'b0, pats[i], 1'b1, 1'b0, 1'b0);
      expReg = pats[i];
      checkOut("parallel load");
    end
    // clocks and serial must be ignored while loading
    pso_host_model_inst.drive(1'b0, 8'h3C, 1'b0, 1'b1, 1'b0);
    pso_host_model_inst.drive(1'b0, 8'h3C, 1'b1, 1'b0, 1'b1);
    pso_host_model_inst.drive(1'b0, 8'h3C, 1'b1, 1'b0, 1'b0);
    checkOut("load ignores clocks");
    drainCheck("load ignores clocks");
  endtask

  task automatic testShift(input logic useB, input logic [7:0] load, input logic [7:0] bits);
    pso_host_model_inst.drive(1'b0, load, 1'b0, 1'b0, 1'b0);
    pso_host_model_inst.drive(1'b1, load, 1'b0, 1'b0, 1'b0);
    expReg = load;
    for (int i = 0; i < 8; i++) begin
      shiftOnce(useB, bits[i]);
      checkOut("serial shift");
    end
    drainCheck("serial shift");
  endtask

  // inhibit raised only while the other clock is high, so only the first rise shifts
  task automatic testInhibit;
    pso_host_model_inst.drive(1'b1, 8'hFF, 1'b1, 1'b1, 1'b0);
    pso_host_model_inst.drive(1'b1, 8'hFF, 1'b1, 1'b1, 1'b1);
    pso_host_model_inst.drive(1'b1, 8'hFF, 1'b1, 1'b0, 1'b1);
    pso_host_model_inst.drive(1'b1, 8'hFF, 1'b1, 1'b1, 1'b1);
    pso_host_model_inst.drive(1'b1, 8'hFF, 1'b1, 1'b0, 1'b1);
    pso_host_model_inst.drive(1'b1, 8'hFF, 1'b1, 1'b0, 1'b0);
    expQ.push_back(expReg[7]);
    expReg = {expReg[6:0], 1'b1};
    checkOut("inhibit");
    drainCheck("inhibit");
  endtask

  task automatic testIdle;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      checkOut("idle");
    end
  endtask

  // receiver stalls: two bits fill the buffer, the third shift must wait, not drop
  task automatic testStall;
    pso_host_model_inst.setReady(1'b0);
    shiftOnce(1'b0, 1'b0);
    shiftOnce(1'b1, 1'b1);
    shiftOnce(1'b0, 1'b1);
    check(shiftedValid, 1'b1, "stall valid");
    check(pso_host_model_inst.got.size() == 0, 1'b1, "stall no pop");
    pso_host_model_inst.setReady(1'b1);
    drainCheck("stall drain");
    repeat (2) @(posedge clock);
    checkOut("stall drain");
  endtask

  // reset, then each scenario in turn
  initial begin
    fails = 0;
    nCompared = 0;
    expReg = 8'h00;
    sys_rst = 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    checkOut("reset");
    check(shiftedValid, 1'b0, "reset valid");
    testLoad();
    testShift(1'b0, 8'hA5, 8'h96);
    testShift(1'b1, 8'h3C, 8'h4B);
    testInhibit();
    testIdle();
    testStall();
    complete_run();
  end
endmodule
